// [src/pcrc_pkg.sv]
// Package of the programmable checksum generator: register indices,
// field positions, reset values, FIFO limits and engine states.
// Assumes a 16-bit register port addressed by word index.
`default_nettype none
package pcrc_pkg;
    // Port and datapath widths
    localparam int unsigned ADDR_W  = 4;
    localparam int unsigned DATA_W  = 16;
    localparam int unsigned WORD_W  = 32;
    localparam int unsigned FIELD_W = 5;
    localparam int unsigned DEPTH   = 16;
    localparam int unsigned PTR_W   = 4;
    // Register indices on the register port
    localparam logic [3:0] REG_CTRL_LO  = 4'h0;
    localparam logic [3:0] REG_CTRL_HI  = 4'h1;
    localparam logic [3:0] REG_POLY_LO  = 4'h2;
    localparam logic [3:0] REG_POLY_HI  = 4'h3;
    localparam logic [3:0] REG_DATA_LO  = 4'h4;
    localparam logic [3:0] REG_DATA_HI  = 4'h5;
    localparam logic [3:0] REG_RES_LO   = 4'h6;
    localparam logic [3:0] REG_RES_HI   = 4'h7;
    localparam logic [3:0] REG_IRQ_STAT = 4'h8;
    localparam logic [3:0] REG_IRQ_MASK = 4'h9;
    // Control-low bit positions
    localparam int unsigned BIT_ENABLE = 15;
    localparam int unsigned BIT_SIDL   = 13;
    localparam int unsigned BIT_FULL   = 7;
    localparam int unsigned BIT_EMPTY  = 6;
    localparam int unsigned BIT_ISEL   = 5;
    localparam int unsigned BIT_GO     = 4;
    localparam int unsigned BIT_LEND   = 3;
    localparam int unsigned BIT_MODE   = 2;
    // Control-high field positions
    localparam int unsigned DW_LSB = 8;
    localparam int unsigned PL_LSB = 0;
    // Interrupt status bits
    localparam int unsigned IRQ_W   = 2;
    localparam int unsigned IRQ_CRC = 0;
    localparam int unsigned IRQ_OVF = 1;
    // FIFO capacity against polynomial length
    localparam logic [4:0] PLEN_LONG_MIN = 5'h07;
    localparam logic [4:0] CAP_LONG      = 5'h08;
    localparam logic [4:0] CAP_SHORT     = 5'h10;
    // Data widths above this index take two writes per word
    localparam logic [4:0] DW_NARROW_MAX = 5'h0F;
    // Reset values
    localparam logic [15:0] REG16_RST = 16'h0000;
    localparam logic [31:0] CRC_RST   = 32'h0000_0000;
    // Shift engine states
    typedef enum logic {ST_IDLE, ST_SHIFT} pcrc_state_type;
endpackage : pcrc_pkg
`default_nettype wire

// [src/pcrc_word_if.sv]
// Word handshake between the FIFO control and the shift engine.
// Assumes both ends share one clock; a word moves when valid and ready.
`timescale 1ns/100ps
`default_nettype none
interface pcrc_word_if #(parameter int unsigned W = 32);
    logic         valid;   // Word on data is usable
    logic         ready;   // Engine can take a word
    logic [W-1:0] data;    // The data word
    modport src (output valid, output data, input ready);
    modport dst (input valid, input data, output ready);
endinterface : pcrc_word_if
`default_nettype wire

// [src/pcrc_fifo_mem.sv]
// Word store of the data FIFO, one write and one registered read port.
// Assumes the caller keeps pointers and never reads an unwritten slot.
`timescale 1ns/100ps
`default_nettype none
module pcrc_fifo_mem #(
    parameter int unsigned WIDTH = 32,
    parameter int unsigned DEPTH = 16,
    parameter int unsigned AW    = 4
) (
    input  wire logic             clk_in,
    input  wire logic             rst_n_in,
    input  wire logic             we_in,
    input  wire logic [AW-1:0]    waddr_in,
    input  wire logic [WIDTH-1:0] wdata_in,
    input  wire logic [AW-1:0]    raddr_in,
    output logic      [WIDTH-1:0] rdata_out
);
    logic [WIDTH-1:0] mem_reg [DEPTH];   // Storage, no reset needed

    // Write port
    always_ff @(posedge clk_in)
    begin
        if (we_in)
            mem_reg[waddr_in] <= wdata_in;
    end

    // Read data always from a register
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            rdata_out <= '0;
        else
            rdata_out <= mem_reg[raddr_in];
    end
endmodule : pcrc_fifo_mem
`default_nettype wire

// [src/pcrc_shifter.sv]
// Serial shift engine: folds one data bit per clock into the checksum.
// Assumes configuration stays steady while a word is shifting.
`timescale 1ns/100ps
`default_nettype none
module pcrc_shifter (
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    input  wire logic        halt_in,      // Freeze, keep state
    input  wire logic        flush_in,     // Abort the word
    input  wire logic [31:0] poly_in,
    input  wire logic [4:0]  plen_in,
    input  wire logic [4:0]  dwidth_in,
    input  wire logic        lsb_first_in,
    input  wire logic        alt_mode_in,
    input  wire logic        seed_lo_we_in,
    input  wire logic        seed_hi_we_in,
    input  wire logic [15:0] seed_in,
    pcrc_word_if.dst         word_if,
    output logic      [31:0] crc_out,
    output logic             busy_out,
    output logic             done_out
);
    pcrc_pkg::pcrc_state_type state_reg;   // Engine state
    logic [31:0] shift_reg;                 // Word being shifted
    logic [4:0]  cnt_reg;                   // Bit index within word
    logic [31:0] mask;                      // Bits inside the length
    logic [31:0] poly_eff;                  // Taps with x^0 always on
    logic [4:0]  sel;                       // Bit to feed next
    logic        in_bit;
    logic        top_bit;
    logic        fb;
    logic [31:0] crc_next;
    logic        last_bit;
    logic        stepping;

    // One mask bit per polynomial position
    for (genvar i = 0; i < 32; i++)
    begin : g_mask
        assign mask[i] = (5'(i) <= plen_in);
    end

    assign poly_eff      = {poly_in[31:1], 1'b1} & mask;
    assign sel           = lsb_first_in ? cnt_reg : 5'(dwidth_in - cnt_reg);
    assign in_bit        = shift_reg[sel];
    assign top_bit       = crc_out[plen_in];
    assign fb            = alt_mode_in ? (top_bit ^ in_bit) : top_bit;
    assign crc_next      = alt_mode_in
                         ? ({crc_out[30:0], 1'b0} ^ (fb ? poly_eff : '0))
                           & mask
                         : ({crc_out[30:0], in_bit} ^ (fb ? poly_eff : '0))
                           & mask;
    assign stepping      = (state_reg == pcrc_pkg::ST_SHIFT) && !halt_in
                           && !flush_in;
    assign last_bit      = stepping && (cnt_reg == dwidth_in);
    assign word_if.ready = (state_reg == pcrc_pkg::ST_IDLE) && !halt_in
                           && !flush_in;
    assign busy_out      = (state_reg == pcrc_pkg::ST_SHIFT);

    // Engine sequencing and checksum update
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            state_reg <= pcrc_pkg::ST_IDLE;
            shift_reg <= '0;
            cnt_reg   <= '0;
            crc_out   <= pcrc_pkg::CRC_RST;
            done_out  <= 1'b0;
        end
        else
        begin
            done_out <= last_bit;
            case (state_reg)
                pcrc_pkg::ST_IDLE:
                begin
                    // Seeding the result only between words
                    if (seed_lo_we_in)
                        crc_out[15:0] <= seed_in;
                    if (seed_hi_we_in)
                        crc_out[31:16] <= seed_in;
                    if (word_if.valid && word_if.ready)
                    begin
                        shift_reg <= word_if.data;
                        cnt_reg   <= '0;
                        state_reg <= pcrc_pkg::ST_SHIFT;
                    end
                end
                pcrc_pkg::ST_SHIFT:
                begin
                    if (flush_in)
                        state_reg <= pcrc_pkg::ST_IDLE;
                    else if (stepping)
                    begin
                        crc_out <= crc_next;
                        cnt_reg <= 5'(cnt_reg + 5'h01);
                        if (last_bit)
                            state_reg <= pcrc_pkg::ST_IDLE;
                    end
                end
                default: state_reg <= pcrc_pkg::ST_IDLE;
            endcase
        end
    end

    chk_bit_per_clock: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        (stepping && !last_bit) |=> (cnt_reg == 5'($past(cnt_reg) + 5'h01))
    ) else $error("Shift engine did not advance one bit");
endmodule : pcrc_shifter
`default_nettype wire

// [src/pcrc_top.sv]
// Top of the programmable checksum generator: register port, data FIFO
// control, interrupt logic and the shift engine.
// Assumes a single 125 MHz clock and a register master that never waits.
//
// The register addresses and the plain strobed port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module pcrc_top (
    input  wire logic        core_clk_in,
    input  wire logic        rst_b_in,
    input  wire logic        idle_mode_in,   // Device is in idle mode
    input  wire logic [3:0]  reg_addr_in,
    input  wire logic [15:0] reg_wdata_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    output logic      [15:0] reg_rdata_out,
    output logic             irq_out
);
    // Reset synchroniser
    logic rst_meta_reg;
    logic rst_n;

    // Control and configuration state
    logic        module_enable_reg;
    logic        stop_in_idle_reg;
    logic        irq_cause_select_reg;
    logic        shifter_start_reg;
    logic        shift_direction_reg;
    logic        calc_variant_reg;
    logic [4:0]  data_width_field_reg;
    logic [4:0]  poly_length_field_reg;
    logic [15:0] poly_lo_reg;        // Bit 0 kept zero
    logic [15:0] poly_hi_reg;
    logic [15:0] hold_lo_reg;        // Low half of a wide data word
    logic [1:0]  irq_stat_reg;
    logic [1:0]  irq_mask_reg;
    logic [1:0]  irq_stat_next;

    // FIFO pointers and count
    logic [3:0]  wr_ptr_reg;
    logic [3:0]  rd_ptr_reg;
    logic [4:0]  fifo_word_count_reg;
    logic        stale_reg;          // Read register not yet current
    logic [4:0]  count_next;

    // Decodes
    wire wr_ctrl_lo = reg_wr_in && (reg_addr_in == pcrc_pkg::REG_CTRL_LO);
    wire wr_ctrl_hi = reg_wr_in && (reg_addr_in == pcrc_pkg::REG_CTRL_HI);
    wire wr_poly_lo = reg_wr_in && (reg_addr_in == pcrc_pkg::REG_POLY_LO);
    wire wr_poly_hi = reg_wr_in && (reg_addr_in == pcrc_pkg::REG_POLY_HI);
    wire wr_data_lo = reg_wr_in && (reg_addr_in == pcrc_pkg::REG_DATA_LO);
    wire wr_data_hi = reg_wr_in && (reg_addr_in == pcrc_pkg::REG_DATA_HI);
    wire wr_res_lo  = reg_wr_in && (reg_addr_in == pcrc_pkg::REG_RES_LO);
    wire wr_res_hi  = reg_wr_in && (reg_addr_in == pcrc_pkg::REG_RES_HI);
    wire wr_mask    = reg_wr_in && (reg_addr_in == pcrc_pkg::REG_IRQ_MASK);
    wire rd_stat    = reg_rd_in && (reg_addr_in == pcrc_pkg::REG_IRQ_STAT);

    // Operating conditions
    wire halt  = !module_enable_reg
               || (stop_in_idle_reg && idle_mode_in);
    wire flush = !module_enable_reg;

    // FIFO capacity follows the polynomial length
    wire [4:0] fifo_cap = (poly_length_field_reg >= pcrc_pkg::PLEN_LONG_MIN)
                        ? pcrc_pkg::CAP_LONG : pcrc_pkg::CAP_SHORT;
    wire fifo_full_flag  = (fifo_word_count_reg >= fifo_cap);
    wire fifo_empty_flag = (fifo_word_count_reg == 5'h00);

    // Narrow words go in with one write, wide words with the high write
    wire narrow   = (data_width_field_reg <= pcrc_pkg::DW_NARROW_MAX);
    wire push_req = module_enable_reg
                  && (narrow ? wr_data_lo : wr_data_hi);
    wire push     = push_req && !fifo_full_flag;
    wire overflow = push_req && fifo_full_flag;
    wire [31:0] push_word = narrow ? {16'h0000, reg_wdata_in}
                                   : {reg_wdata_in, hold_lo_reg};

    // Word channel toward the engine
    pcrc_word_if #(.W(pcrc_pkg::WORD_W)) word_ch ();
    assign word_ch.valid = !fifo_empty_flag && !stale_reg
                         && shifter_start_reg && !halt;
    wire pop = word_ch.valid && word_ch.ready;

    // Engine results
    logic [31:0] crc_value;
    logic        engine_busy;
    logic        engine_done;

    // Interrupt causes
    wire empty_evt = pop && (fifo_word_count_reg == 5'h01) && !push;
    wire done_evt  = engine_done && fifo_empty_flag && !push;
    wire crc_evt   = irq_cause_select_reg ? empty_evt : done_evt;
    wire [1:0] irq_set = {overflow, crc_evt};

    // Read-back images
    wire [15:0] ctrl_lo_img = {module_enable_reg, 1'b0, stop_in_idle_reg,
                               fifo_word_count_reg, fifo_full_flag,
                               fifo_empty_flag, irq_cause_select_reg,
                               shifter_start_reg, shift_direction_reg,
                               calc_variant_reg, 2'b00};
    wire [15:0] ctrl_hi_img = {3'b000, data_width_field_reg,
                               3'b000, poly_length_field_reg};

    // Read multiplexer; unmapped indices read zero
    logic [15:0] rd_mux;
    always_comb
    begin
        case (reg_addr_in)
            pcrc_pkg::REG_CTRL_LO:  rd_mux = ctrl_lo_img;
            pcrc_pkg::REG_CTRL_HI:  rd_mux = ctrl_hi_img;
            pcrc_pkg::REG_POLY_LO:  rd_mux = poly_lo_reg;
            pcrc_pkg::REG_POLY_HI:  rd_mux = poly_hi_reg;
            pcrc_pkg::REG_RES_LO:   rd_mux = crc_value[15:0];
            pcrc_pkg::REG_RES_HI:   rd_mux = crc_value[31:16];
            pcrc_pkg::REG_IRQ_STAT: rd_mux = {14'h0000, irq_stat_reg};
            pcrc_pkg::REG_IRQ_MASK: rd_mux = {14'h0000, irq_mask_reg};
            default:                rd_mux = pcrc_pkg::REG16_RST;
        endcase
    end

    // Count update and sticky status; a new event beats the read clear
    assign count_next    = 5'(fifo_word_count_reg + {4'h0, push}
                              - {4'h0, pop});
    assign irq_stat_next = (rd_stat ? 2'b00 : irq_stat_reg) | irq_set;
    assign irq_out       = |(irq_stat_reg & irq_mask_reg);

    // Reset release through two flops
    always_ff @(posedge core_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            rst_meta_reg <= 1'b0;
            rst_n        <= 1'b0;
        end
        else
        begin
            rst_meta_reg <= 1'b1;
            rst_n        <= rst_meta_reg;
        end
    end

    // Control register writes
    always_ff @(posedge core_clk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            module_enable_reg     <= 1'b0;
            stop_in_idle_reg      <= 1'b0;
            irq_cause_select_reg  <= 1'b0;
            shift_direction_reg   <= 1'b0;
            calc_variant_reg      <= 1'b0;
            data_width_field_reg  <= '0;
            poly_length_field_reg <= '0;
            poly_lo_reg           <= pcrc_pkg::REG16_RST;
            poly_hi_reg           <= pcrc_pkg::REG16_RST;
            irq_mask_reg          <= '0;
        end
        else
        begin
            if (wr_ctrl_lo)
            begin
                module_enable_reg    <= reg_wdata_in[pcrc_pkg::BIT_ENABLE];
                stop_in_idle_reg     <= reg_wdata_in[pcrc_pkg::BIT_SIDL];
                irq_cause_select_reg <= reg_wdata_in[pcrc_pkg::BIT_ISEL];
                shift_direction_reg  <= reg_wdata_in[pcrc_pkg::BIT_LEND];
                calc_variant_reg     <= reg_wdata_in[pcrc_pkg::BIT_MODE];
            end
            if (wr_ctrl_hi)
            begin
                data_width_field_reg  <= reg_wdata_in[pcrc_pkg::DW_LSB +:
                                                      pcrc_pkg::FIELD_W];
                poly_length_field_reg <= reg_wdata_in[pcrc_pkg::PL_LSB +:
                                                      pcrc_pkg::FIELD_W];
            end
            if (wr_poly_lo)
                poly_lo_reg <= {reg_wdata_in[15:1], 1'b0};
            if (wr_poly_hi)
                poly_hi_reg <= reg_wdata_in;
            if (wr_mask)
                irq_mask_reg <= reg_wdata_in[1:0];
        end
    end

    // Start bit: software set wins over the hardware clear
    always_ff @(posedge core_clk_in or negedge rst_n)
    begin
        if (!rst_n)
            shifter_start_reg <= 1'b0;
        else if (wr_ctrl_lo)
            shifter_start_reg <= reg_wdata_in[pcrc_pkg::BIT_GO];
        else if (done_evt || flush)
            shifter_start_reg <= 1'b0;
    end

    // FIFO pointers, count and wide-word holding half
    always_ff @(posedge core_clk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_ptr_reg          <= '0;
            rd_ptr_reg          <= '0;
            fifo_word_count_reg <= '0;
            stale_reg           <= 1'b1;
            hold_lo_reg         <= pcrc_pkg::REG16_RST;
        end
        else if (flush)
        begin
            wr_ptr_reg          <= '0;
            rd_ptr_reg          <= '0;
            fifo_word_count_reg <= '0;
            stale_reg           <= 1'b1;
        end
        else
        begin
            if (wr_data_lo)
                hold_lo_reg <= reg_wdata_in;
            if (push)
                wr_ptr_reg <= 4'(wr_ptr_reg + 4'h1);
            if (pop)
                rd_ptr_reg <= 4'(rd_ptr_reg + 4'h1);
            fifo_word_count_reg <= count_next;
            stale_reg <= pop || (push && fifo_empty_flag);
        end
    end

    // Sticky interrupt status and read data
    always_ff @(posedge core_clk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            irq_stat_reg  <= '0;
            reg_rdata_out <= pcrc_pkg::REG16_RST;
        end
        else
        begin
            irq_stat_reg  <= irq_stat_next;
            reg_rdata_out <= reg_rd_in ? rd_mux : pcrc_pkg::REG16_RST;
        end
    end

    // Word store
    pcrc_fifo_mem #(
        .WIDTH (pcrc_pkg::WORD_W),
        .DEPTH (pcrc_pkg::DEPTH),
        .AW    (pcrc_pkg::PTR_W)
    ) u_mem (
        .clk_in    (core_clk_in),
        .rst_n_in  (rst_n),
        .we_in     (push),
        .waddr_in  (wr_ptr_reg),
        .wdata_in  (push_word),
        .raddr_in  (rd_ptr_reg),
        .rdata_out (word_ch.data)
    );

    // Shift engine
    pcrc_shifter u_shift (
        .clk_in        (core_clk_in),
        .rst_n_in      (rst_n),
        .halt_in       (halt),
        .flush_in      (flush),
        .poly_in       ({poly_hi_reg, poly_lo_reg}),
        .plen_in       (poly_length_field_reg),
        .dwidth_in     (data_width_field_reg),
        .lsb_first_in  (shift_direction_reg),
        .alt_mode_in   (calc_variant_reg),
        .seed_lo_we_in (wr_res_lo),
        .seed_hi_we_in (wr_res_hi),
        .seed_in       (reg_wdata_in),
        .word_if       (word_ch),
        .crc_out       (crc_value),
        .busy_out      (engine_busy),
        .done_out      (engine_done)
    );

    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (!rst_n);

    chk_disable_flush: assert property (
        !module_enable_reg |=> (fifo_word_count_reg == 5'h00)
                               && !engine_busy
    ) else $error("Disabled module kept words or kept shifting");

    chk_idle_stop: assert property (
        (module_enable_reg && stop_in_idle_reg && idle_mode_in && !push)
        |=> fifo_word_count_reg == $past(fifo_word_count_reg)
    ) else $error("FIFO drained while stopped in idle");

    chk_count_track: assert property (
        (push && !pop) |=> fifo_word_count_reg
                           == 5'($past(fifo_word_count_reg) + 5'h01)
    ) else $error("Word count did not follow a push");

    chk_full_refuse: assert property (
        overflow |=> irq_stat_reg[pcrc_pkg::IRQ_OVF]
                     && fifo_word_count_reg <= pcrc_pkg::CAP_SHORT
    ) else $error("Write to a full FIFO was not refused");

    chk_empty_valid: assert property (
        fifo_empty_flag |-> !word_ch.valid
    ) else $error("Empty FIFO offered a word");

    chk_isel_empty: assert property (
        (irq_cause_select_reg && empty_evt) |=>
            irq_stat_reg[pcrc_pkg::IRQ_CRC] && engine_busy
    ) else $error("Empty-cause interrupt missing");

    chk_start_clear: assert property (
        (done_evt && !wr_ctrl_lo) |=> !shifter_start_reg
    ) else $error("Start bit not cleared after last word");

    chk_poly_bit0: assert property (
        (reg_rd_in && reg_addr_in == pcrc_pkg::REG_POLY_LO)
        |=> !reg_rdata_out[0]
    ) else $error("Unimplemented tap bit read as one");

    chk_irq_level: assert property (
        (irq_stat_reg[pcrc_pkg::IRQ_CRC] && irq_mask_reg[pcrc_pkg::IRQ_CRC])
        |-> irq_out
    ) else $error("Unmasked status did not raise the interrupt");
endmodule : pcrc_top
`default_nettype wire

// [tb/pcrc_top_test.sv]
// Self-checking bench of the checksum generator top: registers, FIFO,
// interrupts, idle halt and checksum results. Assumes the package map.
`timescale 1ns/100ps
`default_nettype none
module pcrc_top_test;
    logic        clk = 1'b0;    // Core clock
    logic        rst_b = 1'b0;  // Reset, active low
    logic        idle = 1'b0;   // Device idle mode
    logic [3:0]  addr = 4'h0;   // Register index
    logic [15:0] wdata = 16'h0000;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [15:0] rdata;
    logic        irq;
    logic [15:0] v;             // Last value read
    int          num_errors = 0;
    int          n_tests = 0;
    // Half period of 4 ns gives 125 MHz
    always #4 clk = ~clk;
    pcrc_top dut_u (.core_clk_in(clk), .rst_b_in(rst_b),
        .idle_mode_in(idle), .reg_addr_in(addr), .reg_wdata_in(wdata),
        .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
        .irq_out(irq));
    // Compare and count
    task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    // One-cycle write strobe, gap after it
    task automatic wr_reg(logic [3:0] a, logic [15:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask : wr_reg
    // Read data is taken in the cycle after the strobe edge only
    task automatic rd_reg(logic [3:0] a);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1 v = rdata;
    endtask : rd_reg
    // Bounded wait for the interrupt line, sampled off the edge
    task automatic wait_irq;
        #1;
        for (int i = 0; i < 200 && irq !== 1'b1; i++)
        begin
            @(posedge clk);
            #1;
        end
    endtask : wait_irq
    // Direct or augmented 8-bit checksum, taps x^2 x^1 x^0
    function automatic logic [15:0] model(logic [7:0] d, bit lsb, bit alt);
        logic [15:0] c;
        logic        b;
        logic        fb;
        c = 16'h0000;
        for (int i = 0; i < 8; i++)
        begin
            b  = lsb ? d[i] : d[7-i];
            fb = alt ? c[7] ^ b : c[7];
            c  = {c[14:0], alt ? 1'b0 : b};
            if (fb)
                c = c ^ 16'h0007;
        end
        return c & 16'h00FF;
    endfunction : model
    task automatic t_regs;
        rd_reg(pcrc_pkg::REG_CTRL_LO);
        chk("ctrl_lo rst", v, 16'h0040);
        rd_reg(4'hA);
        chk("unmapped", v, 16'h0000);
        wr_reg(pcrc_pkg::REG_POLY_LO, 16'hFFFF);
        rd_reg(pcrc_pkg::REG_POLY_LO);
        chk("poly_lo", v, 16'hFFFE);
        wr_reg(pcrc_pkg::REG_POLY_HI, 16'hA5C3);
        rd_reg(pcrc_pkg::REG_POLY_HI);
        chk("poly_hi", v, 16'hA5C3);
        wr_reg(pcrc_pkg::REG_CTRL_HI, 16'hFFFF);
        rd_reg(pcrc_pkg::REG_CTRL_HI);
        chk("ctrl_hi", v, 16'h1F1F);
        $display("test registers done");
    endtask : t_regs
    // Fill past capacity for a long and a short length field
    task automatic t_fifo;
        logic [15:0] cap;
        for (int k = 0; k < 2; k++)
        begin
            cap = k ? 16'h0010 : 16'h0008;
            wr_reg(pcrc_pkg::REG_CTRL_HI, k ? 16'h0706 : 16'h0707);
            wr_reg(pcrc_pkg::REG_IRQ_MASK, 16'h0002);
            wr_reg(pcrc_pkg::REG_CTRL_LO, 16'h8000);
            for (int i = 0; i <= cap; i++)
                wr_reg(pcrc_pkg::REG_DATA_LO, 16'h0011);
            rd_reg(pcrc_pkg::REG_CTRL_LO);
            chk("count full", v, 16'h8080 | (cap << 8));
            chk("ovf irq", {15'h0, irq}, 16'h0001);
            rd_reg(pcrc_pkg::REG_IRQ_STAT);
            chk("ovf stat", v, 16'h0002);
            wr_reg(pcrc_pkg::REG_CTRL_LO, 16'h0000);
            rd_reg(pcrc_pkg::REG_CTRL_LO);
            chk("flushed", v, 16'h0040);
        end
        $display("test fifo done");
    endtask : t_fifo
    // Wide words: the low half is held, the high half pushes
    task automatic t_wide;
        wr_reg(pcrc_pkg::REG_CTRL_HI, 16'h1F07);
        wr_reg(pcrc_pkg::REG_CTRL_LO, 16'h8000);
        wr_reg(pcrc_pkg::REG_DATA_LO, 16'h1234);
        rd_reg(pcrc_pkg::REG_CTRL_LO);
        chk("wide lo", v, 16'h8040);
        wr_reg(pcrc_pkg::REG_DATA_HI, 16'h5678);
        rd_reg(pcrc_pkg::REG_CTRL_LO);
        chk("wide hi", v, 16'h8100);
        wr_reg(pcrc_pkg::REG_CTRL_LO, 16'h0000);
        $display("test wide done");
    endtask : t_wide
    // Every direction and mode on one byte, done interrupt
    task automatic t_crc;
        @(posedge clk);
        idle <= 1'b1; // Clear stop bit keeps it running
        for (int m = 0; m < 4; m++)
        begin
            wr_reg(pcrc_pkg::REG_CTRL_HI, 16'h0707);
            wr_reg(pcrc_pkg::REG_POLY_LO, 16'h0006);
            wr_reg(pcrc_pkg::REG_POLY_HI, 16'h0000);
            wr_reg(pcrc_pkg::REG_IRQ_MASK, 16'h0001);
            wr_reg(pcrc_pkg::REG_RES_LO, 16'h0000);
            wr_reg(pcrc_pkg::REG_RES_HI, 16'h0000);
            wr_reg(pcrc_pkg::REG_CTRL_LO, 16'h8010 | (m << 2));
            wr_reg(pcrc_pkg::REG_DATA_LO, 16'h00A5);
            wait_irq;
            chk("done irq", {15'h0, irq}, 16'h0001);
            rd_reg(pcrc_pkg::REG_RES_LO);
            chk("result", v, model(8'hA5, m[1], m[0]));
            rd_reg(pcrc_pkg::REG_CTRL_LO);
            chk("go cleared", v, 16'h8040 | (m << 2));
            rd_reg(pcrc_pkg::REG_IRQ_STAT);
            chk("done stat", v, 16'h0001);
            repeat (2) @(posedge clk);
            #1 chk("irq clear", {15'h0, irq}, 16'h0000);
            wr_reg(pcrc_pkg::REG_CTRL_LO, 16'h0000);
        end
        $display("test checksum done");
    endtask : t_crc
    // Halt in idle, then empty interrupt on release
    task automatic t_idle;
        @(posedge clk);
        idle <= 1'b1;
        wr_reg(pcrc_pkg::REG_CTRL_LO, 16'hA030);
        wr_reg(pcrc_pkg::REG_DATA_LO, 16'h003C);
        repeat (20) @(posedge clk);
        #1 chk("idle irq", {15'h0, irq}, 16'h0000);
        rd_reg(pcrc_pkg::REG_CTRL_LO);
        chk("idle hold", v, 16'hA130);
        @(posedge clk);
        idle <= 1'b0;
        wait_irq;
        chk("empty irq", {15'h0, irq}, 16'h0001);
        $display("test idle done");
    endtask : t_idle
    // Mid-run reset clears interrupt, read data and control
    task automatic t_reset;
        @(posedge clk);
        rst_b <= 1'b0;
        @(posedge clk);
        #1 chk("rst irq", {15'h0, irq}, 16'h0000);
        chk("rst rdata", rdata, 16'h0000);
        @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        rd_reg(pcrc_pkg::REG_CTRL_LO);
        chk("rst ctrl", v, 16'h0040);
        $display("test reset done");
    endtask : t_reset
    task automatic conclude;
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : conclude
    // Main sequence
    initial
    begin
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        t_regs;
        t_fifo;
        t_wide;
        t_crc;
        t_idle;
        t_reset;
        conclude;
    end
    // Watchdog, well past the few hundred cycles needed
    initial
    begin
        #200000;
        num_errors++;
        conclude;
    end
endmodule : pcrc_top_test
`default_nettype wire
